// >>> rtl/psr_map.vh
// register map, field positions, reset values and timing figures of the
// hardware configuration block; definitions only
`ifndef PSR_MAP_VH
`define PSR_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSR_ADDR_W 12
`define PSR_OFF_HARDWARE_CONFIG 12'h000
`define PSR_OFF_IRQ_STAT 12'h004
`define PSR_OFF_IRQ_MASK 12'h008
`define PSR_OFF_ERR 12'h00C
`define PSR_OFF_SYS 12'h010

// ----------------------------------------
// hardware_config fields
// ----------------------------------------
`define PSR_HC_SOFT_RESET_TRIGGER_BIT 0
`define PSR_HC_SOFT_RESET_TIMEOUT_BIT 1
`define PSR_HC_EXT_SEL_BIT 2
`define PSR_HC_STRAP_BIT 3
`define PSR_HC_EXT_SEL_RST 1'h0
`define PSR_HC_SOFT_RESET_TIMEOUT_RST 1'h0

// ----------------------------------------
// interrupt status and mask fields
// ----------------------------------------
`define PSR_IRQ_W 2
`define PSR_IRQ_DONE_BIT 0
`define PSR_IRQ_TO_BIT 1
`define PSR_IRQ_RST 2'h0

// ----------------------------------------
// error register fields
// ----------------------------------------
`define PSR_ERR_TX_BIT 0
`define PSR_ERR_RX_BIT 1
`define PSR_ERR_RST 2'h0

// ----------------------------------------
// system command and status register
// ----------------------------------------
`define PSR_SYS_W 16
`define PSR_SYS_RST 16'h0000
`define PSR_SYS_EXEMPT 16'hFF00

// ----------------------------------------
// timing
// ----------------------------------------
`define PSR_CLK_PERIOD_NS 40
`define PSR_SOFT_RESET_TRIGGER_HOLD_NS 400
`define PSR_SOFT_RESET_TRIGGER_TIMEOUT_NS 20000
`define PSR_STRAP_SETTLE 2'h3

`endif

// >>> rtl/psr_sync3.v
// three-stage synchroniser for a level that arrives from outside the clock
// domain; assumes clk and an asynchronous active-low rstn
`timescale 1ns/10ps

module psr_sync3 #(
   parameter RESET_VAL = 1'b0
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // asynchronous level in
   input wire asyncIn,
   // filtered level out
   output reg syncOut,
   output wire stable
);

   reg stage1_q;
   reg stage2_q;
   reg stage3_q;

   // ----------------------------------------
   // synchroniser chain
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
         stage3_q <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         // a change counts once stages two and three agree
         if (stage2_q == stage3_q) begin
            syncOut <= stage3_q;
         end
      end
   end

   // settled, and the output already carries the settled level
   assign stable = (stage2_q == stage3_q) && (syncOut == stage3_q);

endmodule

// >>> rtl/psr_hw_config.v
// hardware configuration register block: phy presence strap, external port
// select, self-clearing soft reset with timeout, apb slave and interrupt
// assumes one 25 MHz clock, asynchronous active-low reset, apb master
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "psr_map.vh"

// What this block does
// - read-only bit 3 shows the mdio level caught at power-up or hard reset
// - the caught presence strap drives nothing inside, software reads it only
// - bit 2, reset 0, selects external mii port when 1, internal phy when 0
// - port select never steers the management port or the mii clock selection
// - soft reset with phy clocks stopped times out and sets read-only bit 1
// - writing 1 to bit 0 resets mac and system registers except exempt bits
// - soft reset also clears pending transmit and receive error flags
// - the soft reset bit clears itself and reads 0 once the reset is over
// - writes are ignored until one read follows power-up, any reset or wake
module psr_hw_config #(
   parameter SOFT_RESET_TRIGGER_HOLD_NS = `PSR_SOFT_RESET_TRIGGER_HOLD_NS,
   parameter SOFT_RESET_TRIGGER_TIMEOUT_NS = `PSR_SOFT_RESET_TRIGGER_TIMEOUT_NS
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PSR_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // pins and phy status
   input wire mdioIn,
   input wire phyRxClkRunning,
   input wire phyTxClkRunning,
   input wire powerSaveExit,
   // mac side events
   input wire transmitErrorEvent,
   input wire receiveErrorEvent,
   // control outputs
   output reg externalPortSelect,
   output reg macSoftReset,
   output reg irq
);

   // ----------------------------------------
   // timing counts
   // ----------------------------------------
   localparam integer HOLD_CYC_RAW = SOFT_RESET_TRIGGER_HOLD_NS / `PSR_CLK_PERIOD_NS;
   localparam integer HOLD_CYC = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
   localparam integer TO_CYC_RAW = SOFT_RESET_TRIGGER_TIMEOUT_NS / `PSR_CLK_PERIOD_NS;
   localparam integer TO_CYC = (TO_CYC_RAW < 1) ? 1 : TO_CYC_RAW;
   localparam CNT_W = 16;
   localparam [CNT_W-1:0] HOLD_LAST = HOLD_CYC[CNT_W-1:0] - 1'b1;
   localparam [CNT_W-1:0] TO_LAST = TO_CYC[CNT_W-1:0] - 1'b1;

   // soft reset sequencer states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT_PHY = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;

   // ----------------------------------------
   // synchronised pins
   // ----------------------------------------
   wire mdioSync;
   wire mdioStable;
   wire rxRunSync;
   wire txRunSync;
   wire wakeSync;

   psr_sync3 #(.RESET_VAL(1'b0)) uMdioSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn(mdioIn),
      .syncOut(mdioSync),
      .stable(mdioStable)
   );

   psr_sync3 #(.RESET_VAL(1'b0)) uRxRunSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn(phyRxClkRunning),
      .syncOut(rxRunSync),
      .stable()
   );

   psr_sync3 #(.RESET_VAL(1'b0)) uTxRunSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn(phyTxClkRunning),
      .syncOut(txRunSync),
      .stable()
   );

   psr_sync3 #(.RESET_VAL(1'b0)) uWakeSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn(powerSaveExit),
      .syncOut(wakeSync),
      .stable()
   );

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg strapVal_q;
   reg strapDone_q;
   reg [1:0] strapCnt_q;
   reg extSel_q;
   reg srstBusy_q;
   reg srstTo_q;
   reg [1:0] state_q;
   reg [CNT_W-1:0] cnt_q;
   reg [`PSR_IRQ_W-1:0] irqStat_q;
   reg [`PSR_IRQ_W-1:0] irqMask_q;
   reg txErr_q;
   reg rxErr_q;
   reg [`PSR_SYS_W-1:0] sys_q;
   reg readSeen_q;
   reg wakePrev_q;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire accessPhase = psel & penable;
   wire commit = accessPhase & pready;
   wire wrCommit = commit & pwrite & ~pslverr;
   wire rdCommit = commit & ~pwrite;
   // writes before the first read are dropped
   wire wrOk = wrCommit & readSeen_q;
   wire hitHc = (paddr == `PSR_OFF_HARDWARE_CONFIG);
   wire hitStat = (paddr == `PSR_OFF_IRQ_STAT);
   wire hitMask = (paddr == `PSR_OFF_IRQ_MASK);
   wire hitErr = (paddr == `PSR_OFF_ERR);
   wire hitSys = (paddr == `PSR_OFF_SYS);
   wire mapped = hitHc | hitStat | hitMask | hitErr | hitSys;
   wire srstReq = wrOk & hitHc & pwdata[`PSR_HC_SOFT_RESET_TRIGGER_BIT];
   wire wakeRise = wakeSync & ~wakePrev_q;

   // ----------------------------------------
   // soft reset sequencer
   // ----------------------------------------
   wire phyUp = rxRunSync & txRunSync;
   reg [1:0] state_d;
   reg [CNT_W-1:0] cnt_d;
   reg srstDone;
   reg srstTimeout;

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      srstDone = 1'b0;
      srstTimeout = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (srstReq) begin
               state_d = ST_WAIT_PHY;
               cnt_d = {CNT_W{1'b0}};
            end
         end
         ST_WAIT_PHY: begin
            if (phyUp) begin
               state_d = ST_HOLD;
               cnt_d = {CNT_W{1'b0}};
            end else if (cnt_q == TO_LAST) begin
               // phy clocks stopped: give up and flag it
               state_d = ST_IDLE;
               srstTimeout = 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt_q == HOLD_LAST) begin
               state_d = ST_IDLE;
               srstDone = 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = {CNT_W{1'b0}};
         end
      endcase
   end

   // reset pulse applied to registers at the end of the hold
   wire applySrst = srstDone;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cnt_q <= {CNT_W{1'b0}};
         srstBusy_q <= 1'b0;
         macSoftReset <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         // request bit reads 1 only while the sequence runs
         srstBusy_q <= (state_d != ST_IDLE);
         macSoftReset <= (state_d == ST_HOLD);
      end
   end

   // ----------------------------------------
   // presence strap capture
   // ----------------------------------------
   // caught once after reset release when the synchroniser has settled;
   // it only feeds read data
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strapVal_q <= 1'b0;
         strapDone_q <= 1'b0;
         strapCnt_q <= 2'h0;
      end else if (!strapDone_q) begin
         if (strapCnt_q != `PSR_STRAP_SETTLE) begin
            strapCnt_q <= strapCnt_q + 2'h1;
         end else if (mdioStable) begin
            strapVal_q <= mdioSync;
            strapDone_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // hardware_config fields
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extSel_q <= `PSR_HC_EXT_SEL_RST;
         srstTo_q <= `PSR_HC_SOFT_RESET_TIMEOUT_RST;
         externalPortSelect <= `PSR_HC_EXT_SEL_RST;
      end else begin
         // only the data port mux follows this bit
         if (wrOk & hitHc) begin
            extSel_q <= pwdata[`PSR_HC_EXT_SEL_BIT];
         end
         externalPortSelect <= extSel_q;
         // a new request clears the old timeout, a new timeout sets it
         if (srstTimeout) begin
            srstTo_q <= 1'b1;
         end else if (srstReq) begin
            srstTo_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // error flags and system register
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txErr_q <= 1'b0;
         rxErr_q <= 1'b0;
         sys_q <= `PSR_SYS_RST;
      end else if (applySrst) begin
         txErr_q <= 1'b0;
         rxErr_q <= 1'b0;
         // exempt bits survive the soft reset
         sys_q <= (sys_q & `PSR_SYS_EXEMPT) | (`PSR_SYS_RST & ~`PSR_SYS_EXEMPT);
      end else begin
         if (transmitErrorEvent) begin
            txErr_q <= 1'b1;
         end else if (wrOk & hitErr & pwdata[`PSR_ERR_TX_BIT]) begin
            txErr_q <= 1'b0;
         end
         if (receiveErrorEvent) begin
            rxErr_q <= 1'b1;
         end else if (wrOk & hitErr & pwdata[`PSR_ERR_RX_BIT]) begin
            rxErr_q <= 1'b0;
         end
         if (wrOk & hitSys) begin
            sys_q <= pwdata[`PSR_SYS_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // interrupt status, mask and output
   // ----------------------------------------
   wire [`PSR_IRQ_W-1:0] irqSet = {srstTimeout, srstDone};
   wire [`PSR_IRQ_W-1:0] irqClr = (wrOk & hitStat) ? pwdata[`PSR_IRQ_W-1:0] : `PSR_IRQ_RST;
   wire [`PSR_IRQ_W-1:0] irqStat_d = irqSet | (irqStat_q & ~irqClr);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqStat_q <= `PSR_IRQ_RST;
         irqMask_q <= `PSR_IRQ_RST;
         irq <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         if (wrOk & hitMask) begin
            irqMask_q <= pwdata[`PSR_IRQ_W-1:0];
         end
         irq <= |(irqStat_d & irqMask_q);
      end
   end

   // ----------------------------------------
   // read-before-write gate
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readSeen_q <= 1'b0;
         wakePrev_q <= 1'b0;
      end else begin
         wakePrev_q <= wakeSync;
         // soft reset and power-save exit re-arm the gate
         if (applySrst | wakeRise) begin
            readSeen_q <= 1'b0;
         end else if (rdCommit) begin
            readSeen_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [31:0] rdata;

   always @* begin
      rdata = 32'h00000000;
      if (hitHc) begin
         rdata[`PSR_HC_STRAP_BIT] = strapVal_q;
         rdata[`PSR_HC_EXT_SEL_BIT] = extSel_q;
         rdata[`PSR_HC_SOFT_RESET_TIMEOUT_BIT] = srstTo_q;
         rdata[`PSR_HC_SOFT_RESET_TRIGGER_BIT] = srstBusy_q;
      end else if (hitStat) begin
         rdata[`PSR_IRQ_W-1:0] = irqStat_q;
      end else if (hitMask) begin
         rdata[`PSR_IRQ_W-1:0] = irqMask_q;
      end else if (hitErr) begin
         rdata[`PSR_ERR_TX_BIT] = txErr_q;
         rdata[`PSR_ERR_RX_BIT] = rxErr_q;
      end else if (hitSys) begin
         rdata[`PSR_SYS_W-1:0] = sys_q;
      end
   end

   // ----------------------------------------
   // apb answer: one wait state in the access phase
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (accessPhase & ~pready) begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= pwrite ? 32'h00000000 : rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

// >>> dv/psr_phy_model.sv
// phy and mac side model: strap level on mdio, phy clock status, error events
// assumes the block's clock and active-low reset; the bench steers it by levels
`timescale 1ns/10ps
module psr_phy_model (
   // clock and reset
   input wire clk,
   input wire rstn,
   // bench steering
   input wire strapHigh,
   input wire clocksOn,
   input wire [1:0] errKick,
   // block side
   input wire macSoftReset,
   output wire mdioIn,
   output logic phyRxClkRunning,
   output logic phyTxClkRunning,
   output logic transmitErrorEvent,
   output logic receiveErrorEvent
);
   // idle mdio rests at the strap pull level
   assign mdioIn = strapHigh;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phyRxClkRunning <= 1'h0;
         phyTxClkRunning <= 1'h0;
         transmitErrorEvent <= 1'h0;
         receiveErrorEvent <= 1'h0;
      end else begin
         phyRxClkRunning <= clocksOn;
         phyTxClkRunning <= clocksOn;
         // the mac raises no errors while held in reset
         transmitErrorEvent <= errKick[0] & ~macSoftReset;
         receiveErrorEvent <= errKick[1] & ~macSoftReset;
      end
   end
endmodule

// >>> dv/psr_hw_config_properties.sv
// assertion checker for the hardware configuration block
// sees only the top ports; one clock, asynchronous active-low reset
`timescale 1ns/10ps
`include "psr_map.vh"
module psr_hw_config_props #(
   parameter SOFT_RESET_TRIGGER_HOLD_NS = `PSR_SOFT_RESET_TRIGGER_HOLD_NS,
   parameter SOFT_RESET_TRIGGER_TIMEOUT_NS = `PSR_SOFT_RESET_TRIGGER_TIMEOUT_NS
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PSR_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // phy status and outputs
   input wire phyRxClkRunning,
   input wire phyTxClkRunning,
   input wire powerSaveExit,
   input wire externalPortSelect,
   input wire macSoftReset
);
   localparam int HOLD = SOFT_RESET_TRIGGER_HOLD_NS / `PSR_CLK_PERIOD_NS;
   logic commit;
   logic isHc;
   logic gate_q;
   int hiCnt_q;
   assign commit = psel && penable && pready;
   assign isHc = paddr == `PSR_OFF_HARDWARE_CONFIG;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // writes count only after a read since the last reset, wake or soft reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gate_q <= 1'h0;
         hiCnt_q <= 0;
      end else begin
         hiCnt_q <= macSoftReset ? hiCnt_q + 1 : 0;
         if (macSoftReset || powerSaveExit) begin
            gate_q <= 1'h0;
         end else if (commit && !pwrite) begin
            gate_q <= 1'h1;
         end
      end
   end
   pready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > `PSR_OFF_SYS))
      else $error("slave error does not match address");
   unmapped_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   port_read_a: assert property (pready && psel && !pwrite && isHc
      |-> externalPortSelect == prdata[2])
      else $error("port select differs from its register bit");
   port_write_a: assert property (commit && pwrite && gate_q && isHc
      |-> ##2 externalPortSelect == $past(pwdata[2], 2))
      else $error("port select did not follow write");
   write_gate_a: assert property (commit && pwrite && !gate_q && isHc
      |=> $stable(externalPortSelect)[*2])
      else $error("write acted before first read");
   soft_reset_trigger_start_a: assert property (commit && pwrite && gate_q && isHc && pwdata[0]
      && phyRxClkRunning && phyTxClkRunning |-> ##[1:12] macSoftReset)
      else $error("soft reset did not start");
   soft_reset_trigger_phy_a: assert property ($rose(macSoftReset)
      |-> phyRxClkRunning && phyTxClkRunning)
      else $error("mac reset with phy clocks stopped");
   soft_reset_trigger_len_a: assert property ($fell(macSoftReset) |-> hiCnt_q == HOLD)
      else $error("mac reset hold length wrong");
   cover property ($rose(macSoftReset));
   cover property (pready && pslverr);
   cover property (commit && pwrite && !gate_q);
endmodule

bind psr_hw_config psr_hw_config_props #(
   .SOFT_RESET_TRIGGER_HOLD_NS(SOFT_RESET_TRIGGER_HOLD_NS),
   .SOFT_RESET_TRIGGER_TIMEOUT_NS(SOFT_RESET_TRIGGER_TIMEOUT_NS)
) props (
   .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .phyRxClkRunning, .phyTxClkRunning, .powerSaveExit,
   .externalPortSelect, .macSoftReset
);

// >>> dv/tb.sv
// self-checking bench for the hardware configuration block over apb
// assumes the phy model on the far side; one 25 MHz clock
`timescale 1ns/10ps
`include "psr_map.vh"
module tb;
   localparam int HOLD_NS = 200;
   localparam int TO_NS = 2000;
   localparam logic [11:0] HC = `PSR_OFF_HARDWARE_CONFIG;
   localparam logic [11:0] ST = `PSR_OFF_IRQ_STAT;
   localparam logic [11:0] MK = `PSR_OFF_IRQ_MASK;
   localparam logic [11:0] ER = `PSR_OFF_ERR;
   localparam logic [11:0] SY = `PSR_OFF_SYS;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic powerSaveExit = 1'h0;
   logic strapHigh = 1'h1;
   logic clocksOn = 1'h1;
   logic [1:0] errKick = 2'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, mdioIn, phyRxClkRunning, phyTxClkRunning, se;
   logic transmitErrorEvent, receiveErrorEvent, externalPortSelect, macSoftReset, irq;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int n;

   always #20 clk = ~clk;

   psr_hw_config #(.SOFT_RESET_TRIGGER_HOLD_NS(HOLD_NS), .SOFT_RESET_TRIGGER_TIMEOUT_NS(TO_NS)) dut (
      .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .mdioIn, .phyRxClkRunning, .phyTxClkRunning, .powerSaveExit,
      .transmitErrorEvent, .receiveErrorEvent, .externalPortSelect, .macSoftReset, .irq
   );
   psr_phy_model phy (
      .clk, .rstn, .strapHigh, .clocksOn, .errKick, .macSoftReset, .mdioIn,
      .phyRxClkRunning, .phyTxClkRunning, .transmitErrorEvent, .receiveErrorEvent
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; read data and slave error land in rd and se
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string name);
      apb(1'h0, a, 32'h0);
      chk(name, e, rd & m);
   endtask

   task automatic do_reset(input logic strap);
      strapHigh <= strap;
      rstn <= 1'h0;
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      repeat (12) @(posedge clk);
   endtask

   // waits for the mac reset pulse and counts its high cycles in n
   task automatic wait_soft_reset_trigger();
      n = 0;
      while (macSoftReset !== 1'h1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (macSoftReset === 1'h1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         stop_test();
      end
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      do_reset(1'h1);
      apb(1'h1, HC, 32'h4);
      rdchk(HC, 32'hF, 32'h8, "config after reset");
      rdchk(ST, 32'h3, 32'h0, "status reset");
      rdchk(MK, 32'h3, 32'h0, "mask reset");
      rdchk(ER, 32'h3, 32'h0, "errors reset");
      rdchk(SY, 32'hFFFF, 32'h0, "system reset");
      apb(1'h1, HC, 32'h4);
      strapHigh <= 1'h0;
      repeat (3) @(posedge clk);
      rdchk(HC, 32'hF, 32'hC, "select and strap");
      chk("port select", 32'h1, {31'h0, externalPortSelect});
      apb(1'h0, 12'h014, 32'h0);
      chk("unmapped read", 32'h1, {31'h0, se});
      apb(1'h1, 12'h014, 32'hFFFFFFFF);
      chk("unmapped write", 32'h1, {31'h0, se});
      // wake closes the write path until a read
      powerSaveExit <= 1'h1;
      repeat (4) @(posedge clk);
      powerSaveExit <= 1'h0;
      repeat (8) @(posedge clk);
      apb(1'h1, HC, 32'h0);
      rdchk(HC, 32'h4, 32'h4, "write after wake");
      apb(1'h1, SY, 32'hABCD);
      errKick <= 2'h3;
      @(posedge clk);
      errKick <= 2'h0;
      rdchk(ER, 32'h3, 32'h3, "errors set");
      apb(1'h1, HC, 32'h5);
      wait_soft_reset_trigger();
      chk("hold cycles", HOLD_NS / 40, n);
      rdchk(HC, 32'h3, 32'h0, "reset bit clears");
      rdchk(ER, 32'h3, 32'h0, "errors cleared");
      errKick <= 2'h1;
      @(posedge clk);
      errKick <= 2'h0;
      rdchk(ER, 32'h3, 32'h1, "tx error again");
      apb(1'h1, ER, 32'h1);
      rdchk(ER, 32'h3, 32'h0, "error write clear");
      rdchk(SY, 32'hFFFF, 32'hAB00, "system exempt");
      rdchk(ST, 32'h3, 32'h1, "done status");
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'h1, MK, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'h1, ST, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // phy asleep: the reset must time out
      clocksOn <= 1'h0;
      repeat (8) @(posedge clk);
      apb(1'h1, HC, 32'h1);
      repeat (TO_NS / 40 + 20) @(posedge clk);
      chk("no mac reset", 32'h0, {31'h0, macSoftReset});
      rdchk(HC, 32'h3, 32'h2, "timeout flag");
      rdchk(ST, 32'h3, 32'h2, "timeout status");
      chk("irq timeout", 32'h1, {31'h0, irq});
      apb(1'h1, ST, 32'h2);
      clocksOn <= 1'h1;
      repeat (8) @(posedge clk);
      apb(1'h1, HC, 32'h1);
      wait_soft_reset_trigger();
      chk("retry hold", HOLD_NS / 40, n);
      rdchk(HC, 32'h3, 32'h0, "timeout cleared");
      do_reset(1'h0);
      rdchk(HC, 32'hF, 32'h0, "strap low");
      stop_test();
   end
endmodule
